// [design/iqcm_cnt_if.sv]
`timescale 1ns/1ps
interface iqcm_cnt_if;
  logic        clr;
  logic        load;
  logic        inc;
  logic        dec;
  logic [15:0] load_val;
  logic [15:0] limit;
  logic [15:0] count;
  logic        hit;
  modport ctl (output clr, load, inc, dec, load_val, limit, input count, hit);
  modport cnt (input clr, load, inc, dec, load_val, limit, output count, hit);
endinterface : iqcm_cnt_if

// [design/iqcm_pkg.sv]
package iqcm_pkg;

  localparam logic [31:0] STATUS_OFS   = 32'h00013094;
  localparam logic [31:0] DURATION_OFS = 32'h00013098;
  localparam logic [31:0] REORDER_OFS  = 32'h000130a0;

  localparam logic [31:0] STATUS_RST   = 32'h00000000;
  localparam logic [31:0] DURATION_RST = 32'h00000000;
  localparam logic [31:0] REORDER_RST  = 32'h0000ffff;

  localparam int CNT_LSB = 16;
  localparam int CNT_MSB = 31;
  localparam int LIM_LSB = 0;
  localparam int LIM_MSB = 15;

  localparam logic [15:0] CNT_ZERO  = 16'h0000;
  localparam logic [15:0] CNT_ONE   = 16'h0001;
  localparam logic [15:0] CNT_MAX   = 16'hffff;
  localparam logic [31:0] DUR_MAX   = 32'h0000ffff;
  localparam logic [31:0] DUR_ONE   = 32'h00000001;
  localparam logic [15:0] PRE_OFF   = 16'h0000;
  localparam logic [15:0] PRE_ONE   = 16'h0001;
  localparam logic [3:0]  DEPTH_OFF = 4'h0;
  localparam logic        HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    REG_NONE     = 2'b00,
    REG_STATUS   = 2'b01,
    REG_DURATION = 2'b11,
    REG_REORDER  = 2'b10
  } iqcm_reg_t;

  function automatic iqcm_reg_t reg_decode(input logic [31:0] addr);
    iqcm_reg_t r;
    r = REG_NONE;
    if (addr == STATUS_OFS) r = REG_STATUS;
    if (addr == DURATION_OFS) r = REG_DURATION;
    if (addr == REORDER_OFS) r = REG_REORDER;
    return r;
  endfunction : reg_decode

  function automatic logic is_max(input logic [15:0] v);
    return v == CNT_MAX;
  endfunction : is_max

endpackage : iqcm_pkg

// [design/iqcm_sat_counter.sv]
`timescale 1ns/1ps
module iqcm_sat_counter #(
  parameter logic [15:0] RST_VAL = 16'h0000
) (
  input wire logic hclk,
  input wire logic hresetn,
  iqcm_cnt_if.cnt  c
);

  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] count_inc;
  logic        enabled;
  logic        inc_ok;
  logic        dec_ok;

  assign enabled   = c.limit != iqcm_pkg::CNT_ZERO;
  assign count_inc = count_reg + iqcm_pkg::CNT_ONE;
  // A zero limit freezes the count, and the top value is held.
  assign inc_ok = c.inc && enabled && !iqcm_pkg::is_max(count_reg);
  assign dec_ok = c.dec && enabled && count_reg != iqcm_pkg::CNT_ZERO;

  // Clear beats a load, a load beats counting; inc and dec together cancel.
  assign count_next = c.clr ? iqcm_pkg::CNT_ZERO :
                      c.load ? c.load_val :
                      (inc_ok && !dec_ok) ? count_inc :
                      (dec_ok && !inc_ok) ? count_reg - iqcm_pkg::CNT_ONE :
                      count_reg;
  // Hit only on the step that lands on the limit, so it fires once.
  assign c.hit = !c.clr && !c.load && inc_ok && !dec_ok && count_inc == c.limit;
  assign c.count = count_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= RST_VAL;
    end else begin
      count_reg <= count_next;
    end
  end

  property p_limit_zero_freeze;
    @(posedge hclk) disable iff (!hresetn)
    (c.limit == 16'h0000 && !c.clr && !c.load) |=> $stable(count_reg);
  endproperty
  a_limit_zero_freeze: assert property (p_limit_zero_freeze)
    else $error("Counter moved with a zero limit.");

endmodule : iqcm_sat_counter

// [design/iqcm_top.sv]
// Behaviour
// - Queue is congested when occupied buffers reach the fill-level trigger.
// - While congested, each received packet adds one to the event count.
// - Event count stops at 0xffff and holds until cleared; the code still lets an unread leak tick or a status write move it.
// - Software may write any value into event and duration counts.
// - A one written to the inbound congestion flag clears the event count.
// - A zero event limit disables the event count.
// - Event count drops by one when unread for a whole leak interval.
// - Reaching the event limit raises the inbound congestion flag.
// - Status word holds event count and its limit, both reset to zero.
// - While congested, duration count advances once every prescale cycles.
// - Duration count stops at 0xffff though its field is 32 bits.
// - Reading the duration word returns the count and clears it.
// - A zero duration prescale disables the duration count.
// - Each out-of-order fabric pick counts as one reorder event.
// - Reorder count increments per event and stops at 0xffff.
// - A one written to the reorder flag clears the reorder count.
// - Reorder limit resets to 0xffff; zero disables the reorder count.
// - Reorder count equal to its limit raises the reorder flag.
// - Fill-level value n triggers at n+1 buffers; zero disables detection.
// - Prescale 1 advances every congested cycle; 0xffff about once per 64K.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
module iqcm_top #(
  parameter int BUF_W = 5
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic [31:0]           hrdata,
  output logic                  hresp,
  input  wire logic [BUF_W-1:0] rx_buffer_count,
  input  wire logic [3:0]       fill_level_threshold,
  input  wire logic [15:0]      duration_prescale,
  input  wire logic             packet_received,
  input  wire logic             reorder_event,
  input  wire logic             leak_interval_tick,
  input  wire logic             inbound_congestion_flag_clear,
  input  wire logic             reorder_flag_clear,
  output logic                  inbound_congestion_flag,
  output logic                  reorder_flag
);

  iqcm_cnt_if ev ();
  iqcm_cnt_if ro ();

  logic                 hreadyout_reg;
  logic [31:0]          hrdata_reg;
  logic                 hresp_reg;
  logic                 wr_pend_reg;
  iqcm_pkg::iqcm_reg_t  wr_idx_reg;
  logic [15:0]          event_limit_reg;
  logic [15:0]          reorder_limit_reg;
  logic [31:0]          dur_reg;
  logic [31:0]          dur_next;
  logic [15:0]          pre_reg;
  logic [15:0]          pre_next;
  logic                 read_seen_reg;
  logic                 ev_flag_reg;
  logic                 ro_flag_reg;

  logic                 accept;
  logic                 rd_acc;
  iqcm_pkg::iqcm_reg_t  rd_idx;
  logic                 rd_status;
  logic                 rd_dur;
  logic                 wr_status;
  logic                 wr_dur;
  logic                 wr_reorder;
  logic                 fwd;
  logic [31:0]          status_word;
  logic [31:0]          reorder_word;
  logic [31:0]          rd_word;
  logic [BUF_W-1:0]     trigger_level;
  logic                 congested;
  logic                 pre_on;
  logic                 dur_tick;
  logic                 dur_inc_ok;

  // Bus decode. Only NONSEQ and SEQ start a transfer; the slave never waits.
  assign accept    = hsel && hready && htrans[1];
  assign rd_acc    = accept && !hwrite;
  assign rd_idx    = iqcm_pkg::reg_decode(haddr);
  assign rd_status = rd_acc && rd_idx == iqcm_pkg::REG_STATUS;
  assign rd_dur    = rd_acc && rd_idx == iqcm_pkg::REG_DURATION;

  assign wr_status  = wr_pend_reg && wr_idx_reg == iqcm_pkg::REG_STATUS;
  assign wr_dur     = wr_pend_reg && wr_idx_reg == iqcm_pkg::REG_DURATION;
  assign wr_reorder = wr_pend_reg && wr_idx_reg == iqcm_pkg::REG_REORDER;

  // A read right behind a write to the same word sees the new data.
  assign fwd = wr_pend_reg && wr_idx_reg == rd_idx;

  assign status_word  = {ev.count, event_limit_reg};
  assign reorder_word = {ro.count, reorder_limit_reg};

  assign rd_word = (rd_idx == iqcm_pkg::REG_NONE) ? 32'h00000000 :
                   fwd ? hwdata :
                   (rd_idx == iqcm_pkg::REG_STATUS) ? status_word :
                   (rd_idx == iqcm_pkg::REG_DURATION) ? dur_reg :
                   reorder_word;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_reg <= 1'b1;
      hresp_reg     <= iqcm_pkg::HRESP_OKAY;
      hrdata_reg    <= 32'h00000000;
      wr_pend_reg   <= 1'b0;
      wr_idx_reg    <= iqcm_pkg::REG_NONE;
    end else begin
      hreadyout_reg <= 1'b1;
      hresp_reg     <= iqcm_pkg::HRESP_OKAY;
      if (rd_acc) begin
        hrdata_reg <= rd_word;
      end
      wr_pend_reg <= accept && hwrite;
      if (accept) begin
        wr_idx_reg <= iqcm_pkg::reg_decode(haddr);
      end
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hrdata    = hrdata_reg;
  assign hresp     = hresp_reg;

  // Fill-level code n means n+1 buffers, so the top code 15 means sixteen.
  assign trigger_level = BUF_W'(fill_level_threshold) + BUF_W'(1);
  assign congested = fill_level_threshold != iqcm_pkg::DEPTH_OFF &&
                     rx_buffer_count >= trigger_level;

  // Event counter.
  assign ev.clr      = inbound_congestion_flag_clear;
  assign ev.load     = wr_status;
  assign ev.load_val = hwdata[iqcm_pkg::CNT_MSB:iqcm_pkg::CNT_LSB];
  assign ev.limit    = event_limit_reg;
  assign ev.inc      = congested && packet_received;
  // A read in the tick cycle still counts as a read in time.
  assign ev.dec      = leak_interval_tick && !read_seen_reg && !rd_status;

  iqcm_sat_counter #(
    .RST_VAL (iqcm_pkg::STATUS_RST[iqcm_pkg::CNT_MSB:iqcm_pkg::CNT_LSB])
  ) u_event_cnt (
    .hclk    (hclk),
    .hresetn (hresetn),
    .c       (ev)
  );

  // Reorder counter.
  assign ro.clr      = reorder_flag_clear;
  assign ro.load     = wr_reorder;
  assign ro.load_val = hwdata[iqcm_pkg::CNT_MSB:iqcm_pkg::CNT_LSB];
  assign ro.limit    = reorder_limit_reg;
  assign ro.inc      = reorder_event;
  assign ro.dec      = 1'b0;

  iqcm_sat_counter #(
    .RST_VAL (iqcm_pkg::REORDER_RST[iqcm_pkg::CNT_MSB:iqcm_pkg::CNT_LSB])
  ) u_reorder_cnt (
    .hclk    (hclk),
    .hresetn (hresetn),
    .c       (ro)
  );

  // Prescaler restarts whenever congestion breaks, so only unbroken runs count.
  assign pre_on   = congested && duration_prescale != iqcm_pkg::PRE_OFF;
  assign dur_tick = pre_on &&
                    pre_reg >= duration_prescale - iqcm_pkg::PRE_ONE;
  assign pre_next = (!pre_on || dur_tick) ? iqcm_pkg::PRE_OFF :
                    pre_reg + iqcm_pkg::PRE_ONE;
  assign dur_inc_ok = dur_tick && dur_reg < iqcm_pkg::DUR_MAX;

  // A tick in the read cycle lands on the cleared count and is not lost.
  assign dur_next = wr_dur ? hwdata :
                    rd_dur ? (dur_tick ? iqcm_pkg::DUR_ONE : 32'h00000000) :
                    dur_inc_ok ? dur_reg + iqcm_pkg::DUR_ONE :
                    dur_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_reg <= iqcm_pkg::PRE_OFF;
      dur_reg <= iqcm_pkg::DURATION_RST;
    end else begin
      pre_reg <= pre_next;
      dur_reg <= dur_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_limit_reg   <= iqcm_pkg::STATUS_RST[iqcm_pkg::LIM_MSB:iqcm_pkg::LIM_LSB];
      reorder_limit_reg <= iqcm_pkg::REORDER_RST[iqcm_pkg::LIM_MSB:iqcm_pkg::LIM_LSB];
    end else begin
      if (wr_status) begin
        event_limit_reg <= hwdata[iqcm_pkg::LIM_MSB:iqcm_pkg::LIM_LSB];
      end
      if (wr_reorder) begin
        reorder_limit_reg <= hwdata[iqcm_pkg::LIM_MSB:iqcm_pkg::LIM_LSB];
      end
    end
  end

  // Read marker: a read sets it, the tick ends the interval; set wins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      read_seen_reg <= 1'b0;
    end else if (rd_status) begin
      read_seen_reg <= 1'b1;
    end else if (leak_interval_tick) begin
      read_seen_reg <= 1'b0;
    end
  end

  // The flags are one-cycle events; the outside status register keeps them.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_flag_reg <= 1'b0;
      ro_flag_reg <= 1'b0;
    end else begin
      ev_flag_reg <= ev.hit;
      ro_flag_reg <= ro.hit;
    end
  end

  assign inbound_congestion_flag = ev_flag_reg;
  assign reorder_flag            = ro_flag_reg;

  property p_congested;
    @(posedge hclk) disable iff (!hresetn)
    (fill_level_threshold == 4'h1 && rx_buffer_count == BUF_W'(2)) |-> congested;
  endproperty
  a_congested: assert property (p_congested)
    else $error("Two buffers at fill level one not seen as congestion.");

  property p_event_inc;
    @(posedge hclk) disable iff (!hresetn)
    (ev.inc && !ev.dec && !ev.clr && !ev.load && ev.limit != 16'h0000 &&
     ev.count != 16'hffff) |=> ev.count == $past(ev.count) + 16'h0001;
  endproperty
  a_event_inc: assert property (p_event_inc)
    else $error("Event count did not step on a congested packet.");

  property p_event_sat;
    @(posedge hclk) disable iff (!hresetn)
    (ev.count == 16'hffff && !ev.clr && !ev.load && !ev.dec) |=> ev.count == 16'hffff;
  endproperty
  a_event_sat: assert property (p_event_sat)
    else $error("Event count left its top value.");

  property p_event_clear;
    @(posedge hclk) disable iff (!hresetn)
    inbound_congestion_flag_clear |=> ev.count == 16'h0000;
  endproperty
  a_event_clear: assert property (p_event_clear)
    else $error("Event count not cleared.");

  property p_leak;
    @(posedge hclk) disable iff (!hresetn)
    (leak_interval_tick && !read_seen_reg && !rd_status && !ev.inc && !ev.clr &&
     !ev.load && ev.limit != 16'h0000 && ev.count != 16'h0000)
    |=> ev.count == $past(ev.count) - 16'h0001;
  endproperty
  a_leak: assert property (p_leak)
    else $error("Unread event count did not drop by one.");

  property p_event_flag;
    @(posedge hclk) disable iff (!hresetn)
    ev.hit |=> inbound_congestion_flag && ev.count == ev.limit ##1 !inbound_congestion_flag;
  endproperty
  a_event_flag: assert property (p_event_flag)
    else $error("Inbound congestion flag wrong at the limit.");

  sequence s_dur_read;
    rd_dur && !wr_dur && !fwd && !dur_tick;
  endsequence

  sequence s_dur_cleared;
    ##1 (hrdata == $past(dur_reg) && dur_reg == 32'h00000000);
  endsequence

  property p_dur_read;
    @(posedge hclk) disable iff (!hresetn)
    s_dur_read |-> s_dur_cleared;
  endproperty
  a_dur_read: assert property (p_dur_read)
    else $error("Duration read did not return and clear the count.");

  property p_dur_off;
    @(posedge hclk) disable iff (!hresetn)
    (duration_prescale == 16'h0000 && !wr_dur && !rd_dur) |=> $stable(dur_reg);
  endproperty
  a_dur_off: assert property (p_dur_off)
    else $error("Duration count moved with zero prescale.");

  property p_prescale_one;
    @(posedge hclk) disable iff (!hresetn)
    (duration_prescale == 16'h0001 && congested && dur_reg < 32'h0000ffff &&
     !wr_dur && !rd_dur) |=> dur_reg == $past(dur_reg) + 32'h00000001;
  endproperty
  a_prescale_one: assert property (p_prescale_one)
    else $error("Prescale one did not advance every congested cycle.");

  property p_dur_sat;
    @(posedge hclk) disable iff (!hresetn)
    (dur_reg == 32'h0000ffff && !wr_dur && !rd_dur) |=> dur_reg == 32'h0000ffff;
  endproperty
  a_dur_sat: assert property (p_dur_sat)
    else $error("Duration count left its top value.");

  property p_reorder_flag;
    @(posedge hclk) disable iff (!hresetn)
    ro.hit |=> reorder_flag && ro.count == ro.limit;
  endproperty
  a_reorder_flag: assert property (p_reorder_flag)
    else $error("Reorder flag wrong at the limit.");

  property p_reorder_clear;
    @(posedge hclk) disable iff (!hresetn)
    reorder_flag_clear |=> ro.count == 16'h0000 && !reorder_flag;
  endproperty
  a_reorder_clear: assert property (p_reorder_clear)
    else $error("Reorder count not cleared.");

endmodule : iqcm_top

// [sim/tb_iqcm_top.sv]
`timescale 1ns/1ps
module tb_iqcm_top;
  typedef struct packed {
    logic        wr;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] exp;
  } iqcm_row_t;

  localparam logic [31:0] ST  = iqcm_pkg::STATUS_OFS;
  localparam logic [31:0] DU  = iqcm_pkg::DURATION_OFS;
  localparam logic [31:0] RO  = iqcm_pkg::REORDER_OFS;
  localparam logic [31:0] UNM = 32'h0001309c;

  logic        hclk     = 1'b0;
  logic        hresetn  = 1'b0;
  logic [31:0] haddr    = 32'h00000000;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [31:0] hwdata   = 32'h00000000;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic [4:0]  rx_cnt   = 5'h00;
  logic [3:0]  fill_lvl = 4'h0;
  logic [15:0] prescale = 16'h0000;
  // Event pulses: 0 packet, 1 reorder, 2 leak tick, 3 congestion clear, 4 reorder clear.
  logic [4:0]  ev       = 5'h00;
  logic        icf;
  logic        rof;
  int          n_mismatch  = 0;
  int          check_count = 0;
  int          n_icf       = 0;
  int          n_rof       = 0;

  iqcm_top #(.BUF_W(5)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .rx_buffer_count(rx_cnt), .fill_level_threshold(fill_lvl),
    .duration_prescale(prescale), .packet_received(ev[0]), .reorder_event(ev[1]),
    .leak_interval_tick(ev[2]), .inbound_congestion_flag_clear(ev[3]),
    .reorder_flag_clear(ev[4]), .inbound_congestion_flag(icf), .reorder_flag(rof)
  );

  always #12.5 hclk = ~hclk;

  // Counting flag cycles also catches a flag that is held as a level instead of pulsed.
  always @(posedge hclk) begin
    if (icf === 1'b1) n_icf <= n_icf + 1;
    if (rof === 1'b1) n_rof <= n_rof + 1;
  end

  task automatic tally_and_finish;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Values read right after an edge are the ones that stood at that edge.
  task automatic wait_rdy;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 20);
    if (hreadyout !== 1'b1) begin
      chk({31'h00000000, hreadyout}, 32'h00000001);
      tally_and_finish();
    end
  endtask : wait_rdy

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h00000000, x);
    chk(x, e);
    chk({31'h00000000, hresp}, {31'h00000000, iqcm_pkg::HRESP_OKAY});
  endtask : rd_chk

  task automatic pulse(input int k, input int n);
    repeat (n) begin
      ev[k] <= 1'b1;
      @(posedge hclk);
      ev[k] <= 1'b0;
      @(posedge hclk);
    end
  endtask : pulse

  task automatic congest(input int n);
    rx_cnt <= 5'h02;
    repeat (n) @(posedge hclk);
    rx_cnt <= 5'h00;
  endtask : congest

  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    iqcm_row_t rows [9];
    rows = '{
      '{1'b0, ST, 32'h00000000, iqcm_pkg::STATUS_RST},
      '{1'b0, DU, 32'h00000000, iqcm_pkg::DURATION_RST},
      '{1'b0, RO, 32'h00000000, iqcm_pkg::REORDER_RST},
      '{1'b0, UNM, 32'h00000000, 32'h00000000},
      '{1'b1, ST, 32'habcd0003, 32'habcd0003},
      '{1'b1, ST, 32'h00000003, 32'h00000003},
      '{1'b1, DU, 32'h12345678, 32'h12345678},
      '{1'b1, UNM, 32'hffffffff, 32'h00000000},
      '{1'b1, RO, 32'h00000002, 32'h00000002}
    };
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].addr, rows[i].wdata);
      rd_chk(rows[i].addr, rows[i].exp);
    end
    rd_chk(DU, 32'h00000000);
    fill_lvl <= 4'h1;
    rx_cnt <= 5'h01;
    pulse(0, 1);
    rd_chk(ST, 32'h00000003);
    rx_cnt <= 5'h02;
    pulse(0, 3);
    rd_chk(ST, 32'h00030003);
    chk(32'(n_icf), 32'h00000001);
    fill_lvl <= iqcm_pkg::DEPTH_OFF;
    pulse(0, 1);
    rd_chk(ST, 32'h00030003);
    pulse(3, 1);
    rd_chk(ST, 32'h00000003);
    fill_lvl <= 4'h1;
    wr(ST, 32'hfffe0005);
    pulse(0, 2);
    rd_chk(ST, 32'hffff0005);
    wr(ST, 32'h00010000);
    pulse(0, 1);
    rd_chk(ST, 32'h00010000);
    rx_cnt <= 5'h00;
    wr(ST, 32'h00050009);
    rd_chk(ST, 32'h00050009);
    pulse(2, 2);
    rd_chk(ST, 32'h00040009);
    pulse(2, 1);
    // A read taken at the tick edge must hold off the drop for that interval.
    ev[2] <= 1'b1;
    rd_chk(ST, 32'h00040009);
    ev[2] <= 1'b0;
    rd_chk(ST, 32'h00040009);
    prescale <= 16'h0003;
    wr(DU, 32'h00000000);
    congest(10);
    rd_chk(DU, 32'h00000003);
    rd_chk(DU, 32'h00000000);
    prescale <= iqcm_pkg::PRE_ONE;
    congest(5);
    rd_chk(DU, 32'h00000005);
    wr(DU, 32'h0000fffe);
    congest(4);
    rd_chk(DU, iqcm_pkg::DUR_MAX);
    prescale <= iqcm_pkg::PRE_OFF;
    wr(DU, 32'h00000007);
    congest(5);
    rd_chk(DU, 32'h00000007);
    wr(RO, 32'h00000002);
    pulse(1, 3);
    rd_chk(RO, 32'h00030002);
    chk(32'(n_rof), 32'h00000001);
    pulse(4, 1);
    rd_chk(RO, 32'h00000002);
    wr(RO, 32'hfffe0003);
    pulse(1, 2);
    rd_chk(RO, 32'hffff0003);
    wr(RO, 32'h00050000);
    pulse(1, 1);
    rd_chk(RO, 32'h00050000);
    wr(DU, 32'h00000009);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(ST, iqcm_pkg::STATUS_RST);
    rd_chk(RO, iqcm_pkg::REORDER_RST);
    rd_chk(DU, iqcm_pkg::DURATION_RST);
    tally_and_finish();
  end
endmodule : tb_iqcm_top
